// file: tb/nvm_model.sv
// Behavioural memory on the far side of the loader read port
`timescale 1ns/1ns
module nvm_model (
	input  wire logic        clk_in,
	input  wire logic        rd_in,
	input  wire logic [3:0]  addr_in,
	input  wire logic        bad_in,
	output logic      [15:0] data_out
);
	logic [15:0] img [0:8];
	logic [7:0]  c;
	// Image: 1100 mV, 2200 mV, range1 plus ignore straps, address 0x33,
	// pin masks bit0/bit1, only fault 2 shuts down, fault 0 latched, CRC last
	initial begin
		img = '{16'h044c, 16'h0898, 16'h0042, 16'h0033, 16'h0201, 16'h00fb,
			16'h0001, 16'h0000, 16'h0000};
		c = 8'h00;
		for (int w = 0; w < 8; w++)
			for (int b = 15; b >= 0; b--)
				c = {c[6:0], 1'b0} ^ ((c[7] ^ img[w][b]) ? 8'h07 : 8'h00);
		img[8] = {8'h00, c};
		data_out = 16'h0000;
	end
	// Data valid the cycle after a strobe, scrambled otherwise; bad_in spoils the CRC
	always @(posedge clk_in) begin
		data_out <= rd_in ? (img[addr_in] ^ {15'h0000, bad_in & (addr_in == 4'h8)})
			: ~data_out;
	end
endmodule

// file: tb/tb.sv
// Self-checking bench for the configuration loader
`timescale 1ns/1ns
module tb;
	logic CLK_IN = 0, RSTN_IN = 0, INPUT_TURN_ON_THRESHOLD_IN = 1, sh = 0, bad = 0, s;
	logic STRAP_PRESENT_IN = 1, ADDR_LOW_OPEN_IN = 1, ADDR_HIGH_OPEN_IN = 1, RESTORE_IN = 0;
	logic NVM_WR_REQ_IN = 0, NVM_LOG_SEL_IN = 0, PAGE_WR_IN = 0, VOUT_WR_IN = 0;
	logic RANGE_WR_IN = 0, RANGE_DATA_IN = 0, ADDR_PROBE_VALID_IN = 0, STATUS_CLR_IN = 0;
	logic [1:0] PEAK_CMP_IN = 0, CH_CLK_IN = 0;
	logic [12:0] STRAP_VOUT0_IN = 13'h0100, STRAP_VOUT1_IN = 13'h0100, VOUT_DATA_IN = 0;
	logic [3:0] ADDR_STRAP_LOW_IN = 0;
	logic [2:0] ADDR_STRAP_HIGH_IN = 0;
	logic [7:0] NVM_WR_ADDR_IN = 0, PAGE_DATA_IN = 0, FAULT_SRC_IN = 0;
	logic [6:0] ADDR_PROBE_IN = 0;
	logic signed [9:0] DIE_TEMP_IN = 10'sh019;
	logic NVM_RD_OUT, NVM_WR_OUT, INIT_DONE_OUT, NVM_CRC_ERR_OUT, MFR_SUMMARY_OUT, OT_OFF_OUT;
	logic NVM_WR_BLOCK_OUT, ALERT_OE_N_OUT, SHARE_CLK_OE_N_OUT, ADDR_ACK_OUT;
	logic [1:0] FAULT_PIN_OE_N_OUT, RUN_OE_N_OUT, HS_DRIVE_OUT, LS_DRIVE_OUT, DRV_TRI_OUT;
	logic [3:0] NVM_RD_ADDR_OUT;
	logic [15:0] NVM_DATA_IN;
	logic [7:0] NVM_WR_ADDR_OUT, STATUS_OUT;
	logic [6:0] BUS_ADDR_OUT;
	logic [0:0] PAGE_OUT;
	logic [11:0] REF0_OUT, REF1_OUT;
	wire [1:0] RUN_PIN_IN;
	wire SHARE_CLK_IN;
	int miscompares = 0, num_checks = 0, cyc = 0;
	// Open-drain wires with pull-ups
	assign RUN_PIN_IN = RUN_OE_N_OUT;
	assign SHARE_CLK_IN = sh & SHARE_CLK_OE_N_OUT;
	nvm_cfg_init #(.INIT_CYCLES(200), .RETRY_CYCLES(20)) uut (.*);
	nvm_model mem (.clk_in(CLK_IN), .rd_in(NVM_RD_OUT), .addr_in(NVM_RD_ADDR_OUT),
		.bad_in(bad), .data_out(NVM_DATA_IN));
	// Core clock and free-running share clock
	always #5 CLK_IN = ~CLK_IN;
	always begin
		#62 sh = ~sh;
		#63 sh = ~sh;
	end
	// Hang guard
	always @(posedge CLK_IN) begin
		cyc++;
		if (cyc == 5000) begin
			miscompares++;
			finish_test;
		end
	end
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge CLK_IN);
	endtask
	task finish_test;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic prb(input logic [6:0] a, input logic e);
		ADDR_PROBE_IN = a;
		ADDR_PROBE_VALID_IN = 1;
		tick(1);
		ADDR_PROBE_VALID_IN = 0;
		s = 0;
		repeat (2) begin
			s |= ADDR_ACK_OUT;
			tick(1);
		end
		chk("ack", e, s);
	endtask
	task automatic t_init;
		tick(6);
		chk("safe", {2'h0, 2'h3, 2'h3, 2'h0, 1'h0}, {RUN_OE_N_OUT, FAULT_PIN_OE_N_OUT,
			DRV_TRI_OUT, HS_DRIVE_OUT, SHARE_CLK_OE_N_OUT});
		RSTN_IN = 1;
		tick(100);
		chk("early", 3'h0, {INIT_DONE_OUT, RUN_OE_N_OUT});
		repeat (300) if (INIT_DONE_OUT !== 1'b1) tick(1);
		tick(8);
		chk("run", 4'hc, {RUN_OE_N_OUT, DRV_TRI_OUT});
		chk("ref0", 12'h320, REF0_OUT);
		chk("ref1", 12'hc80, REF1_OUT);
		chk("addr", 7'h33, BUS_ADDR_OUT);
	endtask
	task automatic t_cmd;
		logic [7:0] p[2] = '{8'h02, 8'h01};
		for (int i = 0; i < 2; i++) begin
			PAGE_DATA_IN = p[i];
			PAGE_WR_IN = 1;
			tick(1);
			PAGE_WR_IN = 0;
			tick(2);
			chk("page", i, PAGE_OUT);
		end
		VOUT_DATA_IN = 13'h044c;
		VOUT_WR_IN = 1;
		tick(1);
		VOUT_WR_IN = 0;
		tick(3);
		chk("refs0", 12'h320, REF0_OUT);
		chk("refs1", 12'h640, REF1_OUT);
		RANGE_WR_IN = 1;
		tick(1);
		RANGE_WR_IN = 0;
		tick(3);
		chk("range", 12'h320, REF1_OUT);
	endtask
	task automatic t_temp;
		int t[7] = '{131, 127, 124, 161, 151, 149, 20};
		logic [1:0] e[7] = '{2'h2, 2'h2, 2'h0, 2'h3, 2'h3, 2'h2, 2'h0};
		for (int i = 0; i < 7; i++) begin
			DIE_TEMP_IN = 10'(t[i]);
			tick(3);
			chk("temp", e[i], {NVM_WR_BLOCK_OUT, OT_OFF_OUT});
		end
	endtask
	task automatic t_wr;
		logic [7:0] a[3] = '{8'h20, 8'h15, 8'h15};
		for (int i = 0; i < 3; i++) begin
			DIE_TEMP_IN = (i == 2) ? 10'sh083 : 10'sh019;
			tick(3);
			NVM_LOG_SEL_IN = 1;
			NVM_WR_ADDR_IN = a[i];
			NVM_WR_REQ_IN = 1;
			tick(1);
			NVM_WR_REQ_IN = 0;
			s = 0;
			repeat (3) begin
				s |= NVM_WR_OUT;
				tick(1);
			end
			chk("write", i == 1, s);
		end
		chk("waddr", 8'h15, NVM_WR_ADDR_OUT);
		DIE_TEMP_IN = 10'sh019;
		tick(3);
	endtask
	task automatic t_pwm;
		CH_CLK_IN = 2'h3;
		repeat (700) if (HS_DRIVE_OUT !== 2'h3) tick(1);
		CH_CLK_IN = 2'h0;
		chk("drive", 4'hc, {HS_DRIVE_OUT, LS_DRIVE_OUT});
		PEAK_CMP_IN = 2'h1;
		tick(6);
		chk("peak", 4'h9, {HS_DRIVE_OUT, LS_DRIVE_OUT});
		PEAK_CMP_IN = 2'h0;
		tick(6);
		CH_CLK_IN = 2'h1;
		tick(1);
		CH_CLK_IN = 2'h0;
		tick(1);
		chk("cycle", 4'hc, {HS_DRIVE_OUT, LS_DRIVE_OUT});
	endtask
	task automatic t_flt;
		FAULT_SRC_IN = 8'h01;
		tick(3);
		chk("status", 8'h01, STATUS_OUT);
		chk("fpins", 3'h4, {FAULT_PIN_OE_N_OUT, ALERT_OE_N_OUT});
		FAULT_SRC_IN = 8'h02;
		tick(3);
		chk("status", 8'h03, STATUS_OUT);
		chk("gpio", 6'h1c, {FAULT_PIN_OE_N_OUT, HS_DRIVE_OUT, LS_DRIVE_OUT});
		FAULT_SRC_IN = 8'h01;
		STATUS_CLR_IN = 1;
		tick(1);
		chk("set_wins", 8'h01, STATUS_OUT);
		FAULT_SRC_IN = 8'h00;
		tick(1);
		STATUS_CLR_IN = 0;
		chk("clear", 8'h00, STATUS_OUT);
		FAULT_SRC_IN = 8'h04;
		tick(3);
		chk("trip", 6'h30, {FAULT_PIN_OE_N_OUT, HS_DRIVE_OUT, LS_DRIVE_OUT});
		FAULT_SRC_IN = 8'h00;
		CH_CLK_IN = 2'h3;
		tick(10);
		chk("retry", 2'h0, HS_DRIVE_OUT);
		repeat (700) if (HS_DRIVE_OUT !== 2'h3) tick(1);
		CH_CLK_IN = 2'h0;
		chk("restart", 2'h3, HS_DRIVE_OUT);
	endtask
	task automatic t_crc;
		for (int i = 1; i >= 0; i--) begin
			bad = i[0];
			RESTORE_IN = 1;
			tick(1);
			RESTORE_IN = 0;
			tick(60);
			chk("crc", {i[0], i[0]}, {NVM_CRC_ERR_OUT, MFR_SUMMARY_OUT});
			chk("pins", i ? 3'h0 : 3'h7, {ALERT_OE_N_OUT, RUN_OE_N_OUT});
			prb(7'h33, !i[0]);
		end
		bad = 1;
		RESTORE_IN = 1;
		tick(1);
		RESTORE_IN = 0;
		tick(60);
		prb(7'h7c, 1'b1);
		prb(7'h5a, 1'b1);
	endtask
	// Main sequence
	initial begin
		t_init;
		t_cmd;
		t_temp;
		t_wr;
		t_pwm;
		t_flt;
		t_crc;
		finish_test;
	end
endmodule

// file: verilog/nvm_cfg_init.sv
// Power-up configuration loader, memory check and output safety gating
// ==========================================================
`timescale 1ns/1ns
module nvm_cfg_init import nvm_init_pkg::*; #(
	parameter int INIT_CYCLES  = INIT_CYC,
	parameter int RETRY_CYCLES = RETRY_CYC
) (
	// Clock and reset
	input  wire logic               CLK_IN,
	input  wire logic               RSTN_IN,
	// Pins from outside the clock domain
	input  wire logic               INPUT_TURN_ON_THRESHOLD_IN,
	input  wire logic [1:0]         PEAK_CMP_IN,
	input  wire logic [1:0]         RUN_PIN_IN,
	input  wire logic               SHARE_CLK_IN,
	// Strap decoder results
	input  wire logic               STRAP_PRESENT_IN,
	input  wire logic [12:0]        STRAP_VOUT0_IN,
	input  wire logic [12:0]        STRAP_VOUT1_IN,
	input  wire logic [3:0]         ADDR_STRAP_LOW_IN,
	input  wire logic               ADDR_LOW_OPEN_IN,
	input  wire logic [2:0]         ADDR_STRAP_HIGH_IN,
	input  wire logic               ADDR_HIGH_OPEN_IN,
	// Memory read port and write requests
	output logic                    NVM_RD_OUT,
	output logic [3:0]              NVM_RD_ADDR_OUT,
	input  wire logic [15:0]        NVM_DATA_IN,
	input  wire logic               NVM_WR_REQ_IN,
	input  wire logic               NVM_LOG_SEL_IN,
	input  wire logic [7:0]         NVM_WR_ADDR_IN,
	output logic                    NVM_WR_OUT,
	output logic [7:0]              NVM_WR_ADDR_OUT,
	input  wire logic               RESTORE_IN,
	// Bus commands
	input  wire logic               PAGE_WR_IN,
	input  wire logic [7:0]         PAGE_DATA_IN,
	input  wire logic               VOUT_WR_IN,
	input  wire logic [12:0]        VOUT_DATA_IN,
	input  wire logic               RANGE_WR_IN,
	input  wire logic               RANGE_DATA_IN,
	input  wire logic               ADDR_PROBE_VALID_IN,
	input  wire logic [6:0]         ADDR_PROBE_IN,
	input  wire logic               STATUS_CLR_IN,
	// Monitors and switching clocks
	input  wire logic signed [9:0]  DIE_TEMP_IN,
	input  wire logic [7:0]         FAULT_SRC_IN,
	input  wire logic [1:0]         CH_CLK_IN,
	// Status and settings
	output logic                    INIT_DONE_OUT,
	output logic                    NVM_CRC_ERR_OUT,
	output logic                    MFR_SUMMARY_OUT,
	output logic                    NVM_WR_BLOCK_OUT,
	output logic                    OT_OFF_OUT,
	output logic [7:0]              STATUS_OUT,
	output logic [0:0]              PAGE_OUT,
	output logic [6:0]              BUS_ADDR_OUT,
	output logic                    ADDR_ACK_OUT,
	output logic [11:0]             REF0_OUT,
	output logic [11:0]             REF1_OUT,
	// Open-drain pins, enable low while driving low
	output logic                    ALERT_OE_N_OUT,
	output logic [1:0]              FAULT_PIN_OE_N_OUT,
	output logic [1:0]              RUN_OE_N_OUT,
	output logic                    SHARE_CLK_OE_N_OUT,
	// Gate drive
	output logic [1:0]              HS_DRIVE_OUT,
	output logic [1:0]              LS_DRIVE_OUT,
	output logic [1:0]              DRV_TRI_OUT
);

	// ==========================================================
	// Helpers
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [15:0] w);
		logic [7:0] r;
		r = c;
		for (int i = 15; i >= 0; i--) begin
			r = (r[7] ^ w[i]) ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
		end
		return r;
	endfunction

	// Reference LSB is 0.125 mV, 0.0625 mV in range 1; code = mV*8/scale, mV*16/scale in range 1
	function automatic logic [11:0] ref_code(input logic [12:0] mv, input logic rng);
		logic [16:0] num;
		logic [16:0] q;
		num = rng ? {mv, 4'h0} : {1'b0, mv, 3'h0};
		q = num / FB_DIV;
		return (q > 17'h00fff) ? 12'hfff : q[11:0];
	endfunction

	// ==========================================================
	// Declarations
	logic [5:0]    pin_s;
	logic [1:0]    peak_s;
	logic [1:0]    run_s;
	logic          vin_s;
	logic          shclk_s;
	ld_state_t     state_ff;
	logic [3:0]    idx_ff;
	logic [7:0]    crc_ff;
	logic [31:0]   init_cnt_ff;
	logic          apply_ff;
	logic [15:0]   sh_w_ff [9];
	logic          strap_use_ff;
	logic [12:0]   strap_v_ff [2];
	logic [6:0]    strap_a_ff;
	logic [1:0]    strap_open_ff;
	logic [12:0]   vout_mv_ff [2];
	logic [1:0]    range_ff;
	logic [11:0]   ref_ff [2];
	logic [15:0]   cfg_ff;
	logic [15:0]   gpm_ff;
	logic [7:0]    sdm_ff;
	logic [7:0]    stl_ff;
	logic [15:0]   ton_ff;
	logic          wr_block_ff;
	logic          ot_ff;
	logic          off_ff;
	logic [31:0]   retry_ff;
	logic          sd_trip;
	logic          rel_ff;
	logic          sh_low_ff;
	logic [15:0]   sh_cnt_ff;
	logic          sh_prev_ff;
	logic [15:0]   ton_cnt_ff;
	logic          ton_done_ff;
	logic [1:0]    ch_en;
	logic          in_log;
	logic [5:0]    ps_out;

	assign pin_s   = {SHARE_CLK_IN, INPUT_TURN_ON_THRESHOLD_IN, RUN_PIN_IN, PEAK_CMP_IN};
	assign peak_s  = ps_out[1:0];
	assign run_s   = ps_out[3:2];
	assign vin_s   = ps_out[4];
	assign shclk_s = ps_out[5];

	pin_sync3 #(.W(6)) u_sync (
		.clk_in     (CLK_IN),
		.rstn_in    (RSTN_IN),
		.pin_in     (pin_s),
		.stable_out (ps_out)
	);

	// ==========================================================
	// Load sequence: read words, check CRC, wait out init time
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			state_ff        <= ST_IDLE;
			idx_ff          <= 4'h0;
			crc_ff          <= CRC_INIT;
			apply_ff        <= 1'b0;
			NVM_RD_OUT      <= 1'b0;
			NVM_RD_ADDR_OUT <= 4'h0;
			NVM_CRC_ERR_OUT <= 1'b0;
			MFR_SUMMARY_OUT <= 1'b0;
			INIT_DONE_OUT   <= 1'b0;
			strap_use_ff    <= 1'b0;
			strap_a_ff      <= 7'h00;
			strap_open_ff   <= 2'h3;
			for (int i = 0; i < 9; i++) sh_w_ff[i] <= 16'h0000;
			for (int c = 0; c < 2; c++) strap_v_ff[c] <= VOUT_RST;
		end else begin
			apply_ff   <= 1'b0;
			NVM_RD_OUT <= 1'b0;
			case (state_ff)
				ST_IDLE: begin
					// Straps are caught at every load start
					strap_use_ff  <= STRAP_PRESENT_IN;
					strap_v_ff[0] <= STRAP_VOUT0_IN;
					strap_v_ff[1] <= STRAP_VOUT1_IN;
					strap_a_ff    <= {ADDR_STRAP_HIGH_IN, ADDR_STRAP_LOW_IN};
					strap_open_ff <= {ADDR_HIGH_OPEN_IN, ADDR_LOW_OPEN_IN};
					idx_ff        <= 4'h0;
					crc_ff        <= CRC_INIT;
					state_ff      <= ST_READ;
				end
				ST_READ: begin
					NVM_RD_OUT      <= 1'b1;
					NVM_RD_ADDR_OUT <= idx_ff;
					state_ff        <= ST_CAPT;
				end
				ST_CAPT: begin
					// Data returns one cycle after the read strobe
					if (!NVM_RD_OUT) begin
						sh_w_ff[idx_ff] <= NVM_DATA_IN;
						if (idx_ff != W_CRC) begin
							crc_ff   <= crc8(crc_ff, NVM_DATA_IN);
							idx_ff   <= idx_ff + 4'h1;
							state_ff <= ST_READ;
						end else begin
							state_ff <= ST_CHECK;
						end
					end
				end
				ST_CHECK: begin
					// Error stays until a later load checks clean
					NVM_CRC_ERR_OUT <= (crc_ff != sh_w_ff[W_CRC][7:0]);
					MFR_SUMMARY_OUT <= (crc_ff != sh_w_ff[W_CRC][7:0]);
					apply_ff        <= (crc_ff == sh_w_ff[W_CRC][7:0]);
					state_ff        <= INIT_DONE_OUT ? ST_DONE : ST_WAIT;
				end
				ST_WAIT: begin
					if (init_cnt_ff >= 32'(INIT_CYCLES)) begin
						INIT_DONE_OUT <= 1'b1;
						state_ff      <= ST_DONE;
					end
				end
				ST_DONE: begin
					if (RESTORE_IN) state_ff <= ST_IDLE;
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// Init time counts from reset release
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) init_cnt_ff <= 32'h0;
		else if (init_cnt_ff < 32'(INIT_CYCLES)) init_cnt_ff <= init_cnt_ff + 32'h1;
	end

	// ==========================================================
	// Working settings: loaded image, then bus commands
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			for (int c = 0; c < 2; c++) vout_mv_ff[c] <= VOUT_RST;
			range_ff     <= 2'h0;
			cfg_ff       <= 16'h0000;
			gpm_ff       <= 16'h0000;
			sdm_ff       <= 8'h00;
			stl_ff       <= 8'h00;
			ton_ff       <= 16'h0000;
			BUS_ADDR_OUT <= ADDR_RST;
			PAGE_OUT     <= 1'b0;
		end else if (apply_ff) begin
			// Voltage straps win unless absent or ignored; address straps win per nibble unless open
			if (strap_use_ff && !sh_w_ff[W_CFG][CFG_IGN_STRP]) begin
				vout_mv_ff[0] <= strap_v_ff[0];
				vout_mv_ff[1] <= strap_v_ff[1];
			end else begin
				vout_mv_ff[0] <= sh_w_ff[W_VOUT0][12:0];
				vout_mv_ff[1] <= sh_w_ff[W_VOUT1][12:0];
			end
			range_ff     <= {sh_w_ff[W_CFG][CFG_RANGE1], sh_w_ff[W_CFG][CFG_RANGE0]};
			cfg_ff       <= sh_w_ff[W_CFG];
			gpm_ff       <= sh_w_ff[W_GPMASK];
			sdm_ff       <= sh_w_ff[W_SDMASK][7:0];
			stl_ff       <= sh_w_ff[W_STLAT][7:0];
			ton_ff       <= sh_w_ff[W_TON];
			BUS_ADDR_OUT[3:0] <= strap_open_ff[0] ? sh_w_ff[W_ADDR][3:0] : strap_a_ff[3:0];
			BUS_ADDR_OUT[6:4] <= strap_open_ff[1] ? sh_w_ff[W_ADDR][6:4] : strap_a_ff[6:4];
		end else begin
			if (PAGE_WR_IN && PAGE_DATA_IN <= PAGE_MAX) PAGE_OUT <= PAGE_DATA_IN[0];
			if (VOUT_WR_IN) vout_mv_ff[PAGE_OUT] <= VOUT_DATA_IN;
			if (RANGE_WR_IN) range_ff[PAGE_OUT] <= RANGE_DATA_IN;
		end
	end

	// Reference codes follow the settings one cycle later
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			for (int c = 0; c < 2; c++) ref_ff[c] <= 12'h000;
		end else begin
			for (int c = 0; c < 2; c++) ref_ff[c] <= ref_code(vout_mv_ff[c], range_ff[c]);
		end
	end
	assign REF0_OUT = ref_ff[0];
	assign REF1_OUT = ref_ff[1];

	// ==========================================================
	// Temperature gates with hysteresis
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			wr_block_ff <= 1'b0;
			ot_ff       <= 1'b0;
		end else begin
			if (DIE_TEMP_IN > TEMP_WR_OFF) wr_block_ff <= 1'b1;
			else if (DIE_TEMP_IN < TEMP_WR_ON) wr_block_ff <= 1'b0;
			if (DIE_TEMP_IN > TEMP_OT) ot_ff <= 1'b1;
			else if (DIE_TEMP_IN < TEMP_OT_REL) ot_ff <= 1'b0;
		end
	end
	assign NVM_WR_BLOCK_OUT = wr_block_ff;
	assign OT_OFF_OUT       = ot_ff;

	// Memory writes: temperature gate, fault log kept in its region
	assign in_log = (NVM_WR_ADDR_IN >= LOG_FIRST) && (NVM_WR_ADDR_IN <= LOG_LAST);
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			NVM_WR_OUT      <= 1'b0;
			NVM_WR_ADDR_OUT <= 8'h00;
		end else begin
			NVM_WR_OUT <= NVM_WR_REQ_IN && !wr_block_ff && (state_ff == ST_DONE)
				&& (!NVM_LOG_SEL_IN || in_log);
			NVM_WR_ADDR_OUT <= NVM_WR_ADDR_IN;
		end
	end

	// ==========================================================
	// Status, fault pins, alert and address answer
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			STATUS_OUT         <= 8'h00;
			FAULT_PIN_OE_N_OUT <= 2'h3;
			ALERT_OE_N_OUT     <= 1'b1;
			ADDR_ACK_OUT       <= 1'b0;
		end else begin
			// Latched bits: a new event beats the clear
			for (int i = 0; i < 8; i++) begin
				STATUS_OUT[i] <= stl_ff[i]
					? (FAULT_SRC_IN[i] | (STATUS_OUT[i] & !STATUS_CLR_IN))
					: FAULT_SRC_IN[i];
			end
			FAULT_PIN_OE_N_OUT[0] <= !(INIT_DONE_OUT && |(FAULT_SRC_IN & gpm_ff[7:0]));
			FAULT_PIN_OE_N_OUT[1] <= !(INIT_DONE_OUT && |(FAULT_SRC_IN & gpm_ff[15:8]));
			ALERT_OE_N_OUT <= !(NVM_CRC_ERR_OUT || |STATUS_OUT);
			if (NVM_CRC_ERR_OUT) begin
				ADDR_ACK_OUT <= ADDR_PROBE_VALID_IN && (ADDR_PROBE_IN == ADDR_SPECIAL
					|| ADDR_PROBE_IN == ADDR_GLOB0 || ADDR_PROBE_IN == ADDR_GLOB1);
			end else begin
				ADDR_ACK_OUT <= ADDR_PROBE_VALID_IN && (ADDR_PROBE_IN == BUS_ADDR_OUT
					|| ADDR_PROBE_IN == ADDR_GLOB0 || ADDR_PROBE_IN == ADDR_GLOB1);
			end
		end
	end

	// ==========================================================
	// Fault shutdown: latched until both runs low, else hiccup
	assign sd_trip = |(FAULT_SRC_IN & ~sdm_ff) || ot_ff;
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			off_ff   <= 1'b0;
			retry_ff <= 32'h0;
		end else if (sd_trip) begin
			off_ff   <= 1'b1;
			retry_ff <= 32'h0;
		end else if (off_ff) begin
			if (cfg_ff[CFG_LATCH]) begin
				if (run_s == 2'h0) off_ff <= 1'b0;
			end else if (retry_ff >= 32'(RETRY_CYCLES - 1)) begin
				off_ff <= 1'b0;
			end else begin
				retry_ff <= retry_ff + 32'h1;
			end
		end
	end

	// Run pins held low until init, input voltage and clean memory
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			rel_ff       <= 1'b0;
			RUN_OE_N_OUT <= 2'h0;
		end else begin
			rel_ff       <= INIT_DONE_OUT && vin_s;
			RUN_OE_N_OUT <= {2{INIT_DONE_OUT && vin_s && !NVM_CRC_ERR_OUT}};
		end
	end

	// Share clock: held low, then a divider that follows faster peers
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			sh_low_ff          <= 1'b1;
			sh_cnt_ff          <= 16'h0000;
			sh_prev_ff         <= 1'b0;
			SHARE_CLK_OE_N_OUT <= 1'b0;
		end else begin
			sh_prev_ff <= shclk_s;
			if (!rel_ff) begin
				sh_low_ff <= 1'b1;
				sh_cnt_ff <= 16'h0000;
			end else if ((sh_prev_ff && !shclk_s && !sh_low_ff)
				|| sh_cnt_ff >= 16'(SHCLK_HALF - 1)) begin
				sh_low_ff <= !sh_low_ff;
				sh_cnt_ff <= 16'h0000;
			end else begin
				sh_cnt_ff <= sh_cnt_ff + 16'h0001;
			end
			SHARE_CLK_OE_N_OUT <= !(sh_low_ff || !rel_ff);
		end
	end

	// Turn-on delay counted on share clock rising edges
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			ton_cnt_ff  <= 16'h0000;
			ton_done_ff <= 1'b0;
		end else if (!rel_ff || run_s == 2'h0 || off_ff) begin
			ton_cnt_ff  <= 16'h0000;
			ton_done_ff <= 1'b0;
		end else if (!sh_prev_ff && shclk_s && !ton_done_ff) begin
			if (ton_cnt_ff >= ton_ff) ton_done_ff <= 1'b1;
			else ton_cnt_ff <= ton_cnt_ff + 16'h0001;
		end
	end

	// ==========================================================
	// Per-channel switch latch
	assign ch_en = {2{rel_ff && !NVM_CRC_ERR_OUT && !off_ff && !ot_ff && ton_done_ff}} & run_s;
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			HS_DRIVE_OUT <= 2'h0;
			LS_DRIVE_OUT <= 2'h0;
			DRV_TRI_OUT  <= 2'h3;
		end else begin
			for (int c = 0; c < 2; c++) begin
				DRV_TRI_OUT[c] <= !INIT_DONE_OUT;
				if (!ch_en[c]) begin
					HS_DRIVE_OUT[c] <= 1'b0;
					LS_DRIVE_OUT[c] <= 1'b0;
				end else if (peak_s[c]) begin
					HS_DRIVE_OUT[c] <= 1'b0;
					LS_DRIVE_OUT[c] <= 1'b1;
				end else if (CH_CLK_IN[c]) begin
					HS_DRIVE_OUT[c] <= 1'b1;
					LS_DRIVE_OUT[c] <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RSTN_IN);

	chk_page_range: assert property (PAGE_WR_IN && PAGE_DATA_IN > PAGE_MAX |=> $stable(PAGE_OUT))
		else $error("page took a value above one");
	chk_vout_ref: assert property (VOUT_WR_IN && !apply_ff |-> ##2
		($past(PAGE_OUT, 2) ? REF1_OUT : REF0_OUT)
		== ref_code($past(VOUT_DATA_IN, 2), range_ff[$past(PAGE_OUT, 2)]))
		else $error("reference did not follow voltage command");
	chk_hs_reset: assert property (ch_en[0] && peak_s[0] |=> !HS_DRIVE_OUT[0])
		else $error("peak comparator did not end high side");
	chk_wr_block: assert property (wr_block_ff |=> !NVM_WR_OUT)
		else $error("memory write passed while hot");
	chk_ot_drive: assert property (ot_ff |=> HS_DRIVE_OUT == 2'h0)
		else $error("drive active in overtemperature");
	chk_log_region: assert property (NVM_WR_REQ_IN && NVM_LOG_SEL_IN && !in_log |=> !NVM_WR_OUT)
		else $error("fault log wrote outside its region");
	chk_crc_pins: assert property (NVM_CRC_ERR_OUT |=> RUN_OE_N_OUT == 2'h0 && !ALERT_OE_N_OUT)
		else $error("run or alert released after memory error");
	chk_addr_restr: assert property (NVM_CRC_ERR_OUT && ADDR_PROBE_VALID_IN
		&& ADDR_PROBE_IN == BUS_ADDR_OUT && BUS_ADDR_OUT != ADDR_SPECIAL
		&& BUS_ADDR_OUT != ADDR_GLOB0 && BUS_ADDR_OUT != ADDR_GLOB1 |=> !ADDR_ACK_OUT)
		else $error("own address answered after memory error");
	chk_init_safe: assert property (!INIT_DONE_OUT |=> FAULT_PIN_OE_N_OUT == 2'h3
		&& HS_DRIVE_OUT == 2'h0 && RUN_OE_N_OUT == 2'h0 && DRV_TRI_OUT == 2'h3)
		else $error("outputs not safe during init");
	chk_shclk_hold: assert property (!(INIT_DONE_OUT && vin_s) |=> ##1 !SHARE_CLK_OE_N_OUT)
		else $error("share clock released early");

	cov_crc_error: cover property ($rose(NVM_CRC_ERR_OUT));
	cov_init_done: cover property ($rose(INIT_DONE_OUT));
	cov_hiccup:    cover property ($fell(off_ff) && !cfg_ff[CFG_LATCH]);
	cov_switching: cover property ($rose(HS_DRIVE_OUT[1]));

endmodule

// file: verilog/nvm_init_pkg.sv
// Constants and types shared by the configuration loader
package nvm_init_pkg;

	// ==========================================================
	// Clock and times
	localparam int CLK_KHZ      = 100000;            // 100 MHz core clock
	localparam int T_INIT_MS    = 70;                // Typical init time
	localparam int INIT_CYC     = T_INIT_MS * CLK_KHZ;
	localparam int VOUT_LAT_MS  = 10;                // Longest VOUT latency
	localparam int VOUT_LAT_CYC = VOUT_LAT_MS * CLK_KHZ;
	localparam int SHCLK_KHZ    = 100;               // Share clock rate
	localparam int SHCLK_HALF   = CLK_KHZ / (2 * SHCLK_KHZ);
	localparam int RETRY_CYC    = 1000;              // Hiccup off time

	// ==========================================================
	// Die temperature limits, degrees C, signed
	localparam logic signed [9:0] TEMP_WR_OFF = 10'sh082;  // 130
	localparam logic signed [9:0] TEMP_WR_ON  = 10'sh07d;  // 125
	localparam logic signed [9:0] TEMP_OT     = 10'sh0a0;  // 160
	localparam logic signed [9:0] TEMP_OT_HYS = 10'sh00a;  // 10
	localparam logic signed [9:0] TEMP_OT_REL = TEMP_OT - TEMP_OT_HYS;

	// ==========================================================
	// Memory image: word indices and field positions
	localparam logic [3:0] W_VOUT0  = 4'h0;
	localparam logic [3:0] W_VOUT1  = 4'h1;
	localparam logic [3:0] W_CFG    = 4'h2;
	localparam logic [3:0] W_ADDR   = 4'h3;
	localparam logic [3:0] W_GPMASK = 4'h4;
	localparam logic [3:0] W_SDMASK = 4'h5;
	localparam logic [3:0] W_STLAT  = 4'h6;
	localparam logic [3:0] W_TON    = 4'h7;
	localparam logic [3:0] W_CRC    = 4'h8;
	localparam int CFG_RANGE0   = 0;
	localparam int CFG_RANGE1   = 1;
	localparam int CFG_IGN_STRP = 6;                 // Ignore strapping
	localparam int CFG_LATCH    = 8;                 // 1 latched, 0 hiccup
	localparam logic [7:0] LOG_FIRST = 8'h10;        // Fault log region
	localparam logic [7:0] LOG_LAST  = 8'h1f;
	localparam logic [7:0] CRC_INIT  = 8'h00;
	localparam logic [7:0] CRC_POLY  = 8'h07;

	// ==========================================================
	// Bus addresses, page and reset values
	localparam logic [6:0] ADDR_SPECIAL = 7'h7c;
	localparam logic [6:0] ADDR_GLOB0   = 7'h5a;
	localparam logic [6:0] ADDR_GLOB1   = 7'h5b;
	localparam logic [6:0] ADDR_RST     = 7'h40;
	localparam logic [7:0] PAGE_MAX     = 8'h01;
	localparam logic [12:0] VOUT_RST    = 13'h0000;
	localparam logic [16:0] FB_DIV      = 17'h0000b;  // Reference divisor

	// ==========================================================
	// Loader states
	typedef enum logic [5:0] {
		ST_IDLE  = 6'b000001,
		ST_READ  = 6'b000010,
		ST_CAPT  = 6'b000100,
		ST_CHECK = 6'b001000,
		ST_WAIT  = 6'b010000,
		ST_DONE  = 6'b100000
	} ld_state_t;

endpackage

// file: verilog/pin_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module pin_sync3 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk_in,
	input  wire logic         rstn_in,
	// Pins and filtered result
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] stable_out
);

	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;

	// First stage feeds only the second; a bit moves once stages two and three agree
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s1_ff      <= '0;
			s2_ff      <= '0;
			s3_ff      <= '0;
			stable_out <= '0;
		end else begin
			s1_ff <= pin_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			for (int i = 0; i < W; i++) begin
				if (s2_ff[i] == s3_ff[i]) begin
					stable_out[i] <= s3_ff[i];
				end
			end
		end
	end

endmodule
